// ---- rtl/sps_top.sv ----
// Sync PLL supervisor: lock, phase, fallback, faults and APB registers
// What this block does
// - Locks the oscillator only to falling sync edges; rising edges ignored.
// - Channel phase offset from sync fall set by low three config bits.
// - Edge-triggered alignment gives fixed offset and never harmonic lock.
// - Lock is held for external clocks from 100kHz to 750kHz.
// - Lock loss sets status bit 4 and drives alert low.
// - Lock-loss bit stays set until a one is written to it.
// - Masked lock-loss fault does not assert the alert.
// - No external sync: nominal programmed period drives the PWM.
// - External-oscillator mode without sync runs at the lowest frequency.
// - Pad status bit 10 goes low when driving and external present.
// - Cycles are skipped when on-time is below the minimum on-time.
// - As clock source the sync line is pulled low for 500ns.
//
// The placing of the registers and the APB slave port were decided locally.
module sps_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sync_in,
  output logic sync_out,
  output logic sync_oe,
  input wire logic low_sense,
  output logic pwm0,
  output logic pwm1,
  output logic alert_n,
  output logic irq
);
  // ==========================================================
  // Helpers
  function automatic sps_pkg::sps_per_t phase_off(
    input sps_pkg::sps_per_t per, input logic [2:0] code);
    logic [13:0] p;
    p = per * code;
    return p[13:3];
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return a == sps_pkg::ADDR_CTRL || a == sps_pkg::ADDR_PHASE ||
           a == sps_pkg::ADDR_PERIOD || a == sps_pkg::ADDR_ONTIME ||
           a == sps_pkg::ADDR_STATUS || a == sps_pkg::ADDR_MASK ||
           a == sps_pkg::ADDR_PAD || a == sps_pkg::ADDR_LOCK;
  endfunction

  // ==========================================================
  // Submodules
  sps_sync_if sif ();
  logic src_start;
  logic oe_w;
  sps_sync_det u_det (
    .pclk(pclk),
    .presetn(presetn),
    .sync_in(sync_in),
    .sif(sif)
  );
  sps_pulse_gen u_pulse (
    .pclk(pclk),
    .presetn(presetn),
    .start(src_start),
    .sync_oe(oe_w)
  );
  assign sif.own_drive = oe_w;
  assign sync_oe = oe_w;

  // ==========================================================
  // Low sense synchroniser
  logic ls1_q, ls2_q, sout_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ls1_q <= 1'b0;
      ls2_q <= 1'b0;
      sout_q <= 1'b0;
    end else begin
      ls1_q <= low_sense;
      ls2_q <= ls1_q;
      sout_q <= 1'b0;
    end
  end
  assign sync_out = sout_q;

  // ==========================================================
  // Registers
  logic [1:0] ctrl_q, ctrl_d;
  logic [2:0] phase_q, phase_d;
  sps_pkg::sps_per_t period_q, period_d;
  logic [7:0] ontime_q, ontime_d, status_q, status_d, mask_q, mask_d;
  logic [15:0] pad_q, pad_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d, slverr_q, slverr_d;
  logic irq_q, irq_d, alert_n_q, alert_n_d;
  logic wr, lost;
  logic out_en, ext_mode;
  logic locked_q, locked_d;
  sps_pkg::sps_per_t last_q, last_d;

  assign out_en = ctrl_q[sps_pkg::CTRL_OUT_EN_BIT];
  assign ext_mode = ctrl_q[sps_pkg::CTRL_EXT_BIT];
  assign wr = psel & penable & pready_q & pwrite & mapped(paddr);

  always_comb begin
    ctrl_d = ctrl_q;
    phase_d = phase_q;
    period_d = period_q;
    ontime_d = ontime_q;
    mask_d = mask_q;
    if (wr) begin
      unique case (paddr)
        sps_pkg::ADDR_CTRL: ctrl_d = pwdata[1:0];
        sps_pkg::ADDR_PHASE: phase_d = pwdata[2:0];
        sps_pkg::ADDR_PERIOD: period_d = pwdata[10:0];
        sps_pkg::ADDR_ONTIME: ontime_d = pwdata[7:0];
        sps_pkg::ADDR_MASK: mask_d = pwdata[7:0];
        default: ;
      endcase
    end
    // Set wins over a same-cycle write-one clear
    status_d = status_q;
    if (wr && paddr == sps_pkg::ADDR_STATUS) begin
      status_d = status_q & ~pwdata[7:0];
    end
    if (lost) begin
      status_d[sps_pkg::LOCK_LOSS_BIT] = 1'b1;
    end
    irq_d = |(status_d & ~mask_d);
    alert_n_d = ~irq_d;
    pad_d = sps_pkg::PAD_RST;
    pad_d[sps_pkg::PAD_CONFLICT_BIT] = ~(out_en & sif.present);
  end

  // One wait state so read data comes from a flop
  always_comb begin
    pready_d = psel & penable & ~pready_q;
    slverr_d = pready_d & ~mapped(paddr);
    prdata_d = 32'h0000_0000;
    if (pready_d && !pwrite) begin
      unique case (paddr)
        sps_pkg::ADDR_CTRL: prdata_d = {30'h0000_0000, ctrl_q};
        sps_pkg::ADDR_PHASE: prdata_d = {29'h0000_0000, phase_q};
        sps_pkg::ADDR_PERIOD: prdata_d = {21'h00_0000, period_q};
        sps_pkg::ADDR_ONTIME: prdata_d = {24'h00_0000, ontime_q};
        sps_pkg::ADDR_STATUS: prdata_d = {24'h00_0000, status_q};
        sps_pkg::ADDR_MASK: prdata_d = {24'h00_0000, mask_q};
        sps_pkg::ADDR_PAD: prdata_d = {16'h0000, pad_q};
        sps_pkg::ADDR_LOCK: prdata_d = {14'h0000, sif.present, locked_q,
                                        5'h00, last_q};
        default: prdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= sps_pkg::CTRL_RST;
      phase_q <= sps_pkg::PHASE_RST;
      period_q <= sps_pkg::PERIOD_RST;
      ontime_q <= sps_pkg::ONTIME_RST;
      status_q <= 8'h00;
      mask_q <= sps_pkg::MASK_RST;
      pad_q <= sps_pkg::PAD_RST;
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      slverr_q <= 1'b0;
      irq_q <= 1'b0;
      alert_n_q <= 1'b1;
    end else begin
      ctrl_q <= ctrl_d;
      phase_q <= phase_d;
      period_q <= period_d;
      ontime_q <= ontime_d;
      status_q <= status_d;
      mask_q <= mask_d;
      pad_q <= pad_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      slverr_q <= slverr_d;
      irq_q <= irq_d;
      alert_n_q <= alert_n_d;
    end
  end
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = slverr_q;
  assign irq = irq_q;
  assign alert_n = alert_n_q;

  // ==========================================================
  // Lock detection
  logic per_ok;
  sps_pkg::sps_per_t diff;
  always_comb begin
    diff = (sif.period > last_q) ? sif.period - last_q
                                 : last_q - sif.period;
    per_ok = sif.period >= sps_pkg::MIN_PER_CYC &&
             sif.period <= sps_pkg::MAX_PER_CYC &&
             diff <= sps_pkg::LOCK_TOL_CYC;
    locked_d = locked_q;
    last_d = last_q;
    if (sif.timeout) begin
      locked_d = 1'b0;
    end else if (sif.fall) begin
      locked_d = per_ok;
      last_d = sif.period;
    end
    lost = locked_q & ~locked_d;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      locked_q <= 1'b0;
      last_q <= '0;
    end else begin
      locked_q <= locked_d;
      last_q <= last_d;
    end
  end

  // ==========================================================
  // Oscillator and PWM
  // Edge reset of the counter cannot settle on a harmonic
  sps_pkg::sps_per_t cnt_q, cnt_d, per_eff;
  sps_pkg::sps_per_t off [2];
  logic [7:0] on_q [2];
  logic [7:0] on_d [2];
  logic [1:0] pwm_q, pwm_d, start;
  logic [7:0] min_on;
  logic skip;

  always_comb begin
    if (locked_q) begin
      per_eff = last_q;
    end else if (ext_mode) begin
      per_eff = sps_pkg::MAX_PER_CYC;
    end else begin
      per_eff = period_q;
    end
    if (locked_q && sif.fall) begin
      cnt_d = '0;
    end else if (cnt_q + 11'h001 >= per_eff) begin
      cnt_d = '0;
    end else begin
      cnt_d = cnt_q + 11'h001;
    end
    off[0] = phase_off(per_eff, phase_q);
    off[1] = phase_off(per_eff, phase_q + 3'h4);
    min_on = ls2_q ? sps_pkg::MIN_ON_LOW_CYC : sps_pkg::MIN_ON_CYC;
    skip = ontime_q < min_on;
    for (int i = 0; i < 2; i++) begin
      start[i] = cnt_q == off[i];
      if (start[i] && !skip) begin
        on_d[i] = ontime_q;
      end else if (on_q[i] != 8'h00) begin
        on_d[i] = on_q[i] - 8'h01;
      end else begin
        on_d[i] = 8'h00;
      end
      pwm_d[i] = on_d[i] != 8'h00;
    end
  end
  assign src_start = out_en && cnt_q == '0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
      on_q[0] <= 8'h00;
      on_q[1] <= 8'h00;
      pwm_q <= 2'h0;
    end else begin
      cnt_q <= cnt_d;
      on_q[0] <= on_d[0];
      on_q[1] <= on_d[1];
      pwm_q <= pwm_d;
    end
  end
  assign pwm0 = pwm_q[0];
  assign pwm1 = pwm_q[1];

  // ==========================================================
  // Checks
  sequence loss_s;
    locked_q ##1 !locked_q;
  endsequence
  align_edge_a: assert property (@(posedge pclk) disable iff (!presetn)
    (locked_q && sif.fall) |=> cnt_q == '0)
    else $error("oscillator not aligned to sync fall");
  phase_pos_a: assert property (@(posedge pclk) disable iff (!presetn)
    (cnt_q == phase_off(per_eff, phase_q) && !skip && ontime_q > 8'h01)
      |=> pwm_q[0] ##1 pwm_q[0])
    else $error("channel 0 did not start at its phase");
  lock_range_a: assert property (@(posedge pclk) disable iff (!presetn)
    locked_q |-> (last_q >= sps_pkg::MIN_PER_CYC &&
                  last_q <= sps_pkg::MAX_PER_CYC))
    else $error("locked outside supported range");
  loss_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    loss_s |-> status_q[sps_pkg::LOCK_LOSS_BIT] ##1
      (alert_n_q == mask_q[sps_pkg::LOCK_LOSS_BIT] ||
       $past(mask_q[sps_pkg::LOCK_LOSS_BIT]) != mask_q[4]))
    else $error("lock loss not flagged");
  sticky_bit_a: assert property (@(posedge pclk) disable iff (!presetn)
    (status_q[4] && !(wr && paddr == sps_pkg::ADDR_STATUS && pwdata[4]))
      |=> status_q[4])
    else $error("lock-loss bit cleared without write");
  alert_mask_a: assert property (@(posedge pclk) disable iff (!presetn)
    (mask_q[sps_pkg::LOCK_LOSS_BIT] && (status_q & ~mask_q) == 8'h00)
      |-> alert_n_q)
    else $error("masked fault drove alert");
  nominal_per_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!locked_q && !ext_mode) |-> per_eff == period_q)
    else $error("fallback period is not the programmed one");
  lowest_freq_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!locked_q && ext_mode) |-> per_eff == sps_pkg::MAX_PER_CYC)
    else $error("external mode fallback not lowest frequency");
  pad_conflict_a: assert property (@(posedge pclk) disable iff (!presetn)
    (out_en && sif.present) |=> !pad_q[sps_pkg::PAD_CONFLICT_BIT])
    else $error("conflict bit not low");
  skip_cycle_a: assert property (@(posedge pclk) disable iff (!presetn)
    (skip && on_q[0] == 8'h00) |=> !pwm_q[0])
    else $error("pulse issued below minimum on-time");
endmodule

// ---- rtl/sps_pkg.sv ----
// Shared constants and types for the sync PLL supervisor
package sps_pkg;
  // ==========================================================
  // Types
  typedef logic [10:0] sps_per_t;

  // ==========================================================
  // Timing
  localparam int CLK_MHZ = 100;
  localparam int PULSE_NS = 500;
  localparam int PULSE_CYC = (PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int MIN_ON_NS = 90;
  localparam int MIN_ON_LOW_NS = 130;
  localparam logic [7:0] MIN_ON_CYC =
    8'((MIN_ON_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] MIN_ON_LOW_CYC =
    8'((MIN_ON_LOW_NS * CLK_MHZ + 999) / 1000);
  localparam int F_MAX_KHZ = 750;
  localparam int F_MIN_KHZ = 100;
  localparam sps_per_t MIN_PER_CYC = sps_per_t'(CLK_MHZ * 1000 / F_MAX_KHZ);
  localparam sps_per_t MAX_PER_CYC = sps_per_t'(CLK_MHZ * 1000 / F_MIN_KHZ);
  // Timeout longer than the slowest supported period
  localparam sps_per_t TIMEOUT_CYC =
    sps_per_t'(CLK_MHZ * 1000 / F_MIN_KHZ + CLK_MHZ * 250 / F_MIN_KHZ);
  localparam sps_per_t LOCK_TOL_CYC = 11'h008;

  // ==========================================================
  // Register map
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_PHASE = 8'h04;
  localparam logic [7:0] ADDR_PERIOD = 8'h08;
  localparam logic [7:0] ADDR_ONTIME = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_MASK = 8'h14;
  localparam logic [7:0] ADDR_PAD = 8'h18;
  localparam logic [7:0] ADDR_LOCK = 8'h1C;

  // ==========================================================
  // Fields and reset values
  localparam int CTRL_OUT_EN_BIT = 0;
  localparam int CTRL_EXT_BIT = 1;
  localparam int PHASE_W = 3;
  localparam int LOCK_LOSS_BIT = 4;
  localparam int PAD_CONFLICT_BIT = 10;
  localparam int LOCK_LOCKED_BIT = 16;
  localparam int LOCK_PRESENT_BIT = 17;
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [2:0] PHASE_RST = 3'h0;
  localparam sps_per_t PERIOD_RST = 11'h190;
  localparam logic [7:0] ONTIME_RST = 8'h40;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [15:0] PAD_RST = 16'h0400;
endpackage

// ---- rtl/sps_sync_if.sv ----
// Carrier between the sync edge detector and the supervisor core
interface sps_sync_if;
  logic fall;
  logic present;
  logic timeout;
  logic own_drive;
  sps_pkg::sps_per_t period;
  modport det (output fall, output present, output timeout,
               output period, input own_drive);
  modport core (input fall, input present, input timeout,
                input period, output own_drive);
endinterface

// ---- rtl/sps_sync_det.sv ----
// Sync line sampler, falling edge finder, period meter and timeout
module sps_sync_det (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sync_in,
  sps_sync_if.det sif
);
  // ==========================================================
  // Synchroniser
  logic s1_q, s2_q, s3_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
    end else begin
      s1_q <= sync_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // ==========================================================
  // Edge, period and presence
  // Own pulses are masked, so only a peer's edge counts
  logic fall_raw;
  logic fall_q, fall_d, pres_q, pres_d, tmo_q, tmo_d;
  sps_pkg::sps_per_t cnt_q, cnt_d, per_q, per_d;
  assign fall_raw = s3_q & ~s2_q & ~sif.own_drive;

  always_comb begin
    cnt_d = cnt_q;
    per_d = per_q;
    pres_d = pres_q;
    tmo_d = 1'b0;
    if (fall_raw) begin
      per_d = cnt_q + 11'h001;
      cnt_d = '0;
      pres_d = 1'b1;
    end else if (cnt_q < sps_pkg::TIMEOUT_CYC) begin
      cnt_d = cnt_q + 11'h001;
    end else if (pres_q) begin
      pres_d = 1'b0;
      tmo_d = 1'b1;
    end
    fall_d = fall_raw;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
      per_q <= '0;
      pres_q <= 1'b0;
      tmo_q <= 1'b0;
      fall_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      per_q <= per_d;
      pres_q <= pres_d;
      tmo_q <= tmo_d;
      fall_q <= fall_d;
    end
  end

  assign sif.fall = fall_q;
  assign sif.present = pres_q;
  assign sif.timeout = tmo_q;
  assign sif.period = per_q;

  // ==========================================================
  // Checks
  rise_ignored_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s2_q && !s3_q) |=> !fall_q)
    else $error("rising sync edge produced a fall pulse");
  absent_drop_a: assert property (@(posedge pclk) disable iff (!presetn)
    (pres_q && cnt_q == sps_pkg::TIMEOUT_CYC && !fall_raw)
      |=> (!pres_q && tmo_q))
    else $error("sync not declared absent at timeout");
endmodule

// ---- rtl/sps_pulse_gen.sv ----
// Open-drain sync pulse generator for clock-source mode
module sps_pulse_gen (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  output logic sync_oe
);
  localparam int PW = sps_pkg::PULSE_CYC;
  localparam int PW1 = sps_pkg::PULSE_CYC - 1;
  logic [7:0] cnt_q, cnt_d;
  logic oe_q, oe_d;

  always_comb begin
    cnt_d = cnt_q;
    if (start && cnt_q == 8'h00) begin
      cnt_d = 8'(PW);
    end else if (cnt_q != 8'h00) begin
      cnt_d = cnt_q - 8'h01;
    end
    oe_d = cnt_d != 8'h00;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 8'h00;
      oe_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      oe_q <= oe_d;
    end
  end
  assign sync_oe = oe_q;

  pulse_width_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(oe_q) |-> ##PW1 oe_q ##1 !oe_q)
    else $error("sync pulse width wrong");
endmodule

// ---- verification/sps_peer_model.sv ----
// Peer controller model driving the shared open-drain sync line
module sps_peer_model (
  input wire logic en,
  input var int period_ns,
  output logic pull
);
  timeunit 1ns;
  timeprecision 100ps;
  int low_ns;
  // ==========================================================
  // Clock source
  // Released line floats to the pull-up level, so idle reads high
  initial begin
    pull = 1'b0;
    #3;
    forever begin
      wait (en);
      low_ns = (period_ns > 1000) ? 500 : period_ns / 2;
      pull = 1'b1;
      #(low_ns);
      pull = 1'b0;
      #(period_ns - low_ns);
    end
  end
endmodule

// ---- verification/sync_pll_supervisor_test.sv ----
// Self-checking bench for the sync PLL supervisor
module sync_pll_supervisor_test;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {logic [7:0] a; logic [31:0] d; logic e;} sps_row_t;
  logic pclk, presetn, psel, penable, pwrite, low_sense, sync_in, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, sync_out, sync_oe, pwm0, pwm1, alert_n, irq;
  logic peer_en, peer_pull, s_q, p0_q, p1_q, oe_q;
  int peer_ns, bad_count, compares, cyc, fall_cyc, p0_cnt, p0_per, p0_last;
  int p0_lag, p1_lag, p0_w, p0_hi, oe_w, oe_hi, oe_per, oe_last, base, t;
  int mon_t[4] = '{8, 9, 12, 13};
  int pers[4] = '{80, 1340, 10000, 4000};
  sps_row_t rows[7] = '{
    '{sps_pkg::ADDR_CTRL, 32'(sps_pkg::CTRL_RST), 1'b0},
    '{sps_pkg::ADDR_PHASE, 32'(sps_pkg::PHASE_RST), 1'b0},
    '{sps_pkg::ADDR_PERIOD, 32'(sps_pkg::PERIOD_RST), 1'b0},
    '{sps_pkg::ADDR_ONTIME, 32'(sps_pkg::ONTIME_RST), 1'b0},
    '{sps_pkg::ADDR_STATUS, 32'h0000_0000, 1'b0},
    '{sps_pkg::ADDR_MASK, 32'(sps_pkg::MASK_RST), 1'b0},
    '{8'h20, 32'h0000_0000, 1'b1}
  };
  // Open-drain line with pull-up: any party pulling wins
  assign sync_in = !(peer_pull || (sync_oe && !sync_out));

  sps_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sync_in(sync_in), .sync_out(sync_out), .sync_oe(sync_oe),
    .low_sense(low_sense), .pwm0(pwm0), .pwm1(pwm1), .alert_n(alert_n),
    .irq(irq));
  sps_peer_model peer_u (.en(peer_en), .period_ns(peer_ns),
    .pull(peer_pull));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // ==========================================================
  // Edge timing monitors
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    s_q <= sync_in;
    p0_q <= pwm0;
    p1_q <= pwm1;
    oe_q <= sync_oe;
    if (s_q && !sync_in) fall_cyc <= cyc;
    if (!p0_q && pwm0) begin
      p0_cnt <= p0_cnt + 1;
      p0_per <= cyc - p0_last;
      p0_last <= cyc;
      p0_lag <= cyc - fall_cyc;
    end
    if (!p1_q && pwm1) p1_lag <= cyc - fall_cyc;
    p0_hi <= pwm0 ? p0_hi + 1 : 0;
    if (p0_q && !pwm0) p0_w <= p0_hi;
    oe_hi <= sync_oe ? oe_hi + 1 : 0;
    if (oe_q && !sync_oe) oe_w <= oe_hi;
    if (!oe_q && sync_oe) begin
      oe_per <= cyc - oe_last;
      oe_last <= cyc;
    end
  end

  // ==========================================================
  // Tasks
  task automatic tally_and_finish();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      bad_count++;
      tally_and_finish();
    end
  endtask

  task automatic waitc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic wait_p0(input int k);
    int goal;
    goal = p0_cnt + k;
    for (int i = 0; i < 5000 && p0_cnt < goal; i++) @(posedge pclk);
    if (p0_cnt < goal) begin
      bad_count++;
      tally_and_finish();
    end
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    low_sense = 1'b0;
    peer_en = 1'b0;
    peer_ns = 4000;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      apb(1'b0, rows[i].a, 32'h0000_0000);
      chk("reset rdata", rows[i].d, rd);
      chk("slverr", {31'h0, rows[i].e}, {31'h0, err});
    end
    apb(1'b0, sps_pkg::ADDR_PAD, 32'h0000_0000);
    chk("pad reset", 32'(sps_pkg::PAD_RST), rd);
    $display("test registers done");
    wait_p0(3);
    chk("free period", 32'(sps_pkg::PERIOD_RST), p0_per);
    chk("on time", 32'(sps_pkg::ONTIME_RST), p0_w);
    apb(1'b1, sps_pkg::ADDR_CTRL, 32'h0000_0002);
    wait_p0(3);
    chk("ext osc period", 32'd1000, p0_per);
    apb(1'b1, sps_pkg::ADDR_CTRL, 32'h0000_0000);
    $display("test fallback done");
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, sps_pkg::ADDR_ONTIME, 32'(mon_t[i]));
      low_sense <= (i > 1);
      t = (i > 1) ? sps_pkg::MIN_ON_LOW_CYC : sps_pkg::MIN_ON_CYC;
      waitc(420);
      base = p0_cnt;
      waitc(420);
      chk("min on width", (mon_t[i] < t) ? 0 : mon_t[i],
          (p0_cnt == base) ? 0 : p0_w);
    end
    low_sense <= 1'b0;
    apb(1'b1, sps_pkg::ADDR_ONTIME, 32'(sps_pkg::ONTIME_RST));
    $display("test min on time done");
    apb(1'b1, sps_pkg::ADDR_CTRL, 32'h0000_0001);
    waitc(1000);
    chk("pulse width", sps_pkg::PULSE_CYC, oe_w);
    chk("sync out", 32'h0, {31'h0, sync_out});
    chk("pulse period", 32'(sps_pkg::PERIOD_RST), oe_per);
    apb(1'b1, sps_pkg::ADDR_CTRL, 32'h0000_0000);
    $display("test clock source done");
    // Each step may lose lock when the peer stops, so clear first
    for (int i = 0; i < 4; i++) begin
      peer_en <= 1'b0;
      waitc(1400);
      apb(1'b1, sps_pkg::ADDR_STATUS, 32'h0000_0010);
      peer_ns = pers[i];
      peer_en <= 1'b1;
      waitc(pers[i] * 6 / 10 + 100);
      apb(1'b0, sps_pkg::ADDR_LOCK, 32'h0000_0000);
      if (i == 0) chk("no lock", 32'h0000_0000, rd & 32'h0001_0000);
      else chk("lock", 32'h0003_0000 | pers[i] / 10, rd & 32'h0003_07ff);
    end
    $display("test lock range done");
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, sps_pkg::ADDR_PHASE, 32'(k));
      waitc(900);
      if (k == 0) base = p0_lag;
      chk("ch0 phase", base + 400 * k / 8, p0_lag);
      chk("ch1 phase", p0_lag + 200, p1_lag);
    end
    $display("test phase done");
    apb(1'b1, sps_pkg::ADDR_CTRL, 32'h0000_0001);
    waitc(20);
    apb(1'b0, sps_pkg::ADDR_PAD, 32'h0000_0000);
    chk("pad conflict", 32'h0000_0000, rd);
    apb(1'b1, sps_pkg::ADDR_CTRL, 32'h0000_0000);
    waitc(2500);
    apb(1'b1, sps_pkg::ADDR_STATUS, 32'h0000_0010);
    apb(1'b0, sps_pkg::ADDR_PAD, 32'h0000_0000);
    chk("pad clear", 32'(sps_pkg::PAD_RST), rd);
    $display("test conflict done");
    peer_en <= 1'b0;
    for (int i = 0; i < 3000 && alert_n !== 1'b0; i++) @(posedge pclk);
    chk("alert low", 32'h0, {31'h0, alert_n});
    chk("irq high", 32'h1, {31'h0, irq});
    apb(1'b0, sps_pkg::ADDR_LOCK, 32'h0000_0000);
    chk("lock gone", 32'h0000_0000, rd & 32'h0003_0000);
    waitc(500);
    apb(1'b0, sps_pkg::ADDR_STATUS, 32'h0000_0000);
    chk("loss sticky", 32'h0000_0010, rd);
    apb(1'b1, sps_pkg::ADDR_STATUS, 32'h0000_0010);
    waitc(3);
    chk("alert clear", 32'h1, {31'h0, alert_n});
    apb(1'b0, sps_pkg::ADDR_STATUS, 32'h0000_0000);
    chk("loss clear", 32'h0000_0000, rd);
    $display("test lock loss done");
    apb(1'b1, sps_pkg::ADDR_MASK, 32'h0000_0010);
    peer_en <= 1'b1;
    waitc(2500);
    peer_en <= 1'b0;
    waitc(1500);
    apb(1'b0, sps_pkg::ADDR_STATUS, 32'h0000_0000);
    chk("masked loss", 32'h0000_0010, rd);
    chk("masked alert", 32'h1, {31'h0, alert_n});
    chk("masked irq", 32'h0, {31'h0, irq});
    $display("test mask done");
    tally_and_finish();
  end
endmodule
